// ==== scp_pkg.sv ====
// shared constants for the serial configuration port: target addresses,
// map offsets, reset values, apb register map, timing and state encodings.
// assumes a 40 MHz system clock feeding both ends.
package scp_pkg;
  // 7-bit main-map target address with the strap bit cleared (0x40 >> 1)
  localparam logic [6:0] MAIN_ADDR_BASE = 7'h20;
  localparam int ADDR_STRAP_BIT = 0;
  localparam int DIR_BIT = 0;
  // main-map control offsets
  localparam logic [7:0] SUBMAP_SEL_OFS = 8'h0E;
  localparam logic [7:0] PP_ADDR_OFS = 8'hFD;
  localparam logic [7:0] SO_ADDR_OFS = 8'hFE;
  localparam int SEL_LSB = 5;
  localparam int SEL_MSB = 6;
  localparam logic [1:0] SEL_USER = 2'h0;
  localparam logic [1:0] SEL_VBI = 2'h1;
  localparam logic [1:0] SEL_USER2 = 2'h2;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] PP_ADDR_RESET = 8'h00;
  localparam logic [7:0] SO_ADDR_RESET = 8'h00;
  // internal map indices
  localparam logic [2:0] MAP_USER = 3'h0;
  localparam logic [2:0] MAP_VBI = 3'h1;
  localparam logic [2:0] MAP_USER2 = 3'h2;
  localparam logic [2:0] MAP_PP = 3'h3;
  localparam logic [2:0] MAP_SO = 3'h4;
  localparam int MAP_COUNT = 5;
  localparam logic [7:0] SUB_MAX_DEFAULT = 8'hFE;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // controller apb map
  localparam logic [11:0] CMD_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_READ_BIT = 2;
  localparam int CMD_NACK_BIT = 3;
  localparam int CMD_BYTE_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ACK_BIT = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam int STAT_BYTE_LSB = 8;
  // link timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // target states
  typedef enum logic [7:0] {
    D_IDLE = 8'h01, D_ADDR = 8'h02, D_AACK = 8'h04, D_SUBA = 8'h08,
    D_WDATA = 8'h10, D_WACK = 8'h20, D_RDATA = 8'h40, D_RACK = 8'h80
  } scp_dev_state_t;
  // controller states
  typedef enum logic [3:0] {
    H_IDLE = 4'h1, H_START = 4'h2, H_BITS = 4'h4, H_STOP = 4'h8
  } scp_host_state_t;
endpackage : scp_pkg

// ==== scp_if.sv ====
// two-wire link between controller and target.
// resolves the open-drain wires from the enables; pull-ups are implied.
`timescale 1ns/100ps
interface scp_if;
  logic hostSclO;
  logic hostSclOe;
  logic hostSdaO;
  logic hostSdaOe;
  logic devSdaO;
  logic devSdaOe;
  logic scl;
  logic sda;
  // wired-and with pull-up
  assign scl = hostSclOe ? hostSclO : 1'b1;
  assign sda = (hostSdaOe ? hostSdaO : 1'b1) & (devSdaOe ? devSdaO : 1'b1);
  modport dev(input scl, input sda, output devSdaO, output devSdaOe);
  modport host(input scl, input sda, output hostSclO, output hostSclOe, output hostSdaO, output hostSdaOe);
endinterface : scp_if

// ==== scp_sync.sv ====
// three-stage input synchroniser with agreement filter.
// assumes din is asynchronous to clk.
`timescale 1ns/100ps
module scp_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic din,
  output logic level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  // level follows only once stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      lvl_r <= RESET_VAL;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        lvl_r <= s3_r;
      end
    end
  end
  assign level = lvl_r;
endmodule : scp_sync

// ==== scp_device.sv ====
// two-wire target port: address decode, subaddress auto-increment and map steering.
// assumes the link arrives asynchronously and the controller keeps bus timing.
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module scp_device import scp_pkg::*; #(
  parameter logic [7:0] SUB_MAX = SUB_MAX_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  scp_if.dev link,
  input wire logic addressSelectPin,
  output logic [7:0] subMapSelector,
  output logic [7:0] postprocMapTargetAddress,
  output logic [7:0] serialOutMapTargetAddress,
  output logic busy
);
  if (SUB_MAX < SUBMAP_SEL_OFS) begin : g_bad_sub_max
    $error("SUB_MAX must cover the selector register");
  end

  scp_dev_state_t state_r;
  logic sclS;
  logic sdaS;
  logic strapS;
  logic sclD_r;
  logic sdaD_r;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r;
  logic [7:0] txByte_r;
  logic [7:0] sub_r;
  logic [2:0] map_r;
  logic dir_r;
  logic past_r;
  logic oe_r;
  logic [7:0] sel_r;
  logic [7:0] ppAddr_r;
  logic [7:0] soAddr_r;
  logic [7:0] mem [0:MAP_COUNT-1][0:255];
  logic sclRise;
  logic sclFall;
  logic startC;
  logic stopC;
  logic rxDone;
  logic mainHit;
  logic ppHit;
  logic soHit;
  logic [2:0] hitMap;
  logic [7:0] rdVal;
  logic wrEn;
  logic mainMap;

  // line and strap synchronisers
  scp_sync #(.RESET_VAL(1'b1)) u_scl (.clk(clk), .reset_n(reset_n), .din(link.scl), .level(sclS));
  scp_sync #(.RESET_VAL(1'b1)) u_sda (.clk(clk), .reset_n(reset_n), .din(link.sda), .level(sdaS));
  scp_sync #(.RESET_VAL(1'b0)) u_strap (.clk(clk), .reset_n(reset_n), .din(addressSelectPin), .level(strapS));

  // delayed copies of filtered lines for edge finding
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      sclD_r <= sclS;
      sdaD_r <= sdaS;
    end
  end

  // bus events from filtered levels
  assign sclRise = sclS & ~sclD_r;
  assign sclFall = ~sclS & sclD_r;
  assign startC = sclS & sclD_r & sdaD_r & ~sdaS;
  assign stopC = sclS & sclD_r & ~sdaD_r & sdaS;
  assign rxDone = sclFall && (bitCnt_r == BITS_PER_BYTE);

  // target address decode
  assign mainHit = shift_r[7:1] == (MAIN_ADDR_BASE | {6'h00, strapS});
  assign ppHit = (ppAddr_r[7:1] != 7'h00) && (shift_r[7:1] == ppAddr_r[7:1]);
  assign soHit = (soAddr_r[7:1] != 7'h00) && (shift_r[7:1] == soAddr_r[7:1]);

  // map steering: selector picks the main-address sub map, pp and so maps by address hit
  always_comb begin
    hitMap = MAP_SO;
    if (mainHit) begin
      case (sel_r[SEL_MSB:SEL_LSB])
        SEL_VBI: hitMap = MAP_VBI;
        SEL_USER2: hitMap = MAP_USER2;
        default: hitMap = MAP_USER;
      endcase
    end else if (ppHit) begin
      hitMap = MAP_PP;
    end
  end

  // read mux, control registers overlay the array
  assign mainMap = map_r <= MAP_USER2;
  always_comb begin
    rdVal = mem[map_r][sub_r];
    if (mainMap && sub_r == SUBMAP_SEL_OFS) begin
      rdVal = sel_r;
    end else if (map_r == MAP_USER && sub_r == PP_ADDR_OFS) begin
      rdVal = ppAddr_r;
    end else if (map_r == MAP_USER && sub_r == SO_ADDR_OFS) begin
      rdVal = soAddr_r;
    end
  end

  assign wrEn = (state_r == D_WDATA) && rxDone && !past_r;

  // protocol state machine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= D_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      txByte_r <= 8'h00;
      sub_r <= 8'h00;
      map_r <= MAP_USER;
      dir_r <= 1'b0;
      past_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (stopC) begin
      state_r <= D_IDLE;
      oe_r <= 1'b0;
    end else if (startC) begin
      state_r <= D_ADDR;
      bitCnt_r <= 4'h0;
      oe_r <= 1'b0;
    end else begin
      case (state_r)
        D_ADDR, D_SUBA, D_WDATA: begin
          if (sclRise && bitCnt_r < BITS_PER_BYTE) begin
            shift_r <= {shift_r[6:0], sdaS};
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (rxDone) begin
            bitCnt_r <= 4'h0;
            if (state_r == D_ADDR) begin
              if (mainHit || ppHit || soHit) begin
                oe_r <= 1'b1;
                dir_r <= shift_r[DIR_BIT];
                map_r <= hitMap;
                state_r <= D_AACK;
              end else begin
                state_r <= D_IDLE;
              end
            end else if (state_r == D_SUBA) begin
              if (shift_r > SUB_MAX) begin
                state_r <= D_IDLE;
              end else begin
                sub_r <= shift_r;
                past_r <= 1'b0;
                oe_r <= 1'b1;
                state_r <= D_WACK;
              end
            end else if (past_r) begin
              state_r <= D_IDLE;
            end else begin
              oe_r <= 1'b1;
              state_r <= D_WACK;
              if (sub_r == SUB_MAX) begin
                past_r <= 1'b1;
              end else begin
                sub_r <= sub_r + 8'h01;
              end
            end
          end
        end
        D_AACK: begin
          if (sclFall) begin
            bitCnt_r <= 4'h0;
            if (dir_r) begin
              txByte_r <= rdVal;
              oe_r <= ~rdVal[7];
              state_r <= D_RDATA;
            end else begin
              oe_r <= 1'b0;
              state_r <= D_SUBA;
            end
          end
        end
        D_WACK: begin
          if (sclFall) begin
            oe_r <= 1'b0;
            bitCnt_r <= 4'h0;
            state_r <= D_WDATA;
          end
        end
        D_RDATA: begin
          if (sclRise) begin
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (sclFall) begin
            if (bitCnt_r == BITS_PER_BYTE) begin
              oe_r <= 1'b0;
              state_r <= D_RACK;
            end else begin
              oe_r <= ~txByte_r[3'h7 - bitCnt_r[2:0]];
            end
          end
        end
        D_RACK: begin
          if (sclRise) begin
            if (sdaS) begin
              state_r <= D_IDLE;
            end else if (sub_r != SUB_MAX) begin
              sub_r <= sub_r + 8'h01;
            end
          end else if (sclFall) begin
            txByte_r <= rdVal;
            oe_r <= ~rdVal[7];
            bitCnt_r <= 4'h0;
            state_r <= D_RDATA;
          end
        end
        default: begin
          oe_r <= 1'b0;
        end
      endcase
    end
  end

  // control registers written over the link
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_r <= SEL_RESET;
      ppAddr_r <= PP_ADDR_RESET;
      soAddr_r <= SO_ADDR_RESET;
    end else if (wrEn) begin
      if (mainMap && sub_r == SUBMAP_SEL_OFS) begin
        sel_r <= shift_r;
      end
      if (map_r == MAP_USER && sub_r == PP_ADDR_OFS) begin
        ppAddr_r <= shift_r;
      end
      if (map_r == MAP_USER && sub_r == SO_ADDR_OFS) begin
        soAddr_r <= shift_r;
      end
    end
  end

  // register contents of every map
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[map_r][sub_r] <= shift_r;
    end
  end

  assign link.devSdaO = 1'b0;
  assign link.devSdaOe = oe_r;
  assign subMapSelector = sel_r;
  assign postprocMapTargetAddress = ppAddr_r;
  assign serialOutMapTargetAddress = soAddr_r;
  assign busy = state_r != D_IDLE;
endmodule : scp_device

// ==== scp_host.sv ====
// two-wire bus controller driven byte by byte from apb registers.
// assumes no clock stretching by the target; scl is generated by a divider.
`timescale 1ns/100ps
module scp_host import scp_pkg::*; #(
  parameter int QUARTER = QUARTER_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  scp_if.host link
);
  if (QUARTER < 2 || QUARTER > 65535) begin : g_bad_quarter
    $error("QUARTER must lie in 2..65535");
  end

  scp_host_state_t state_r;
  logic [15:0] div_r;
  logic [1:0] q_r;
  logic [3:0] bitIdx_r;
  logic sclOe_r;
  logic sdaOe_r;
  logic doStart_r;
  logic doStop_r;
  logic doRead_r;
  logic doNack_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic ackSeen_r;
  logic done_r;
  logic [31:0] prdata_r;
  logic sdaS;
  logic tick;
  logic busy;
  logic access;
  logic mapped;
  logic cmdWr;

  scp_sync #(.RESET_VAL(1'b1)) u_sda (.clk(clk), .reset_n(reset_n), .din(link.sda), .level(sdaS));

  assign busy = state_r != H_IDLE;
  assign access = psel & penable;
  assign mapped = (paddr == CMD_OFS) || (paddr == STAT_OFS);
  assign cmdWr = access && pwrite && (paddr == CMD_OFS) && !busy;
  assign tick = div_r == 16'(QUARTER - 1);

  // apb answers in the first access cycle
  assign pready = access;
  assign pslverr = access && (!mapped || (pwrite && paddr == CMD_OFS && busy));
  assign prdata = prdata_r;

  // read data captured in the setup cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= 32'h0000_0000;
      if (paddr == STAT_OFS) begin
        prdata_r[STAT_BUSY_BIT] <= busy;
        prdata_r[STAT_ACK_BIT] <= ackSeen_r;
        prdata_r[STAT_DONE_BIT] <= done_r;
        prdata_r[STAT_BYTE_LSB +: 8] <= rx_r;
      end
    end
  end

  // command latch; the byte may be any target address or data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      doStart_r <= 1'b0;
      doStop_r <= 1'b0;
      doRead_r <= 1'b0;
      doNack_r <= 1'b0;
      tx_r <= 8'h00;
    end else if (cmdWr) begin
      doStart_r <= pwdata[CMD_START_BIT];
      doStop_r <= pwdata[CMD_STOP_BIT];
      doRead_r <= pwdata[CMD_READ_BIT];
      doNack_r <= pwdata[CMD_NACK_BIT];
      tx_r <= pwdata[CMD_BYTE_LSB +: 8];
    end
  end

  // quarter-period divider, runs only while busy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= 16'h0000;
    end else if (!busy || tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // bus sequencer, one action per quarter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= H_IDLE;
      q_r <= 2'h0;
      bitIdx_r <= 4'h0;
      sclOe_r <= 1'b0;
      sdaOe_r <= 1'b0;
      rx_r <= 8'h00;
      ackSeen_r <= 1'b0;
      done_r <= 1'b0;
    end else if (state_r == H_IDLE) begin
      if (cmdWr) begin
        done_r <= 1'b0;
        q_r <= 2'h0;
        bitIdx_r <= 4'h0;
        state_r <= pwdata[CMD_START_BIT] ? H_START : H_BITS;
      end
    end else if (tick) begin
      q_r <= q_r + 2'h1;
      case (state_r)
        H_START: begin
          case (q_r)
            2'h0: sdaOe_r <= 1'b0;
            2'h1: sclOe_r <= 1'b0;
            2'h2: sdaOe_r <= 1'b1;
            default: begin
              sclOe_r <= 1'b1;
              state_r <= H_BITS;
            end
          endcase
        end
        H_BITS: begin
          case (q_r)
            2'h0: begin
              if (bitIdx_r < BITS_PER_BYTE) begin
                sdaOe_r <= doRead_r ? 1'b0 : ~tx_r[3'h7 - bitIdx_r[2:0]];
              end else begin
                sdaOe_r <= doRead_r ? ~doNack_r : 1'b0;
              end
            end
            2'h1: sclOe_r <= 1'b0;
            2'h2: begin
              if (bitIdx_r < BITS_PER_BYTE) begin
                rx_r <= {rx_r[6:0], sdaS};
              end else begin
                ackSeen_r <= ~sdaS;
              end
            end
            default: begin
              sclOe_r <= 1'b1;
              if (bitIdx_r == BITS_PER_BYTE) begin
                state_r <= doStop_r ? H_STOP : H_IDLE;
                done_r <= !doStop_r;
              end else begin
                bitIdx_r <= bitIdx_r + 4'h1;
              end
            end
          endcase
        end
        H_STOP: begin
          case (q_r)
            2'h0: sdaOe_r <= 1'b1;
            2'h1: sclOe_r <= 1'b0;
            2'h2: sdaOe_r <= 1'b0;
            default: begin
              state_r <= H_IDLE;
              done_r <= 1'b1;
            end
          endcase
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign link.hostSclO = 1'b0;
  assign link.hostSclOe = sclOe_r;
  assign link.hostSdaO = 1'b0;
  assign link.hostSdaOe = sdaOe_r;
endmodule : scp_host

// ==== scp_monitor.sv ====
// checker for the two-wire link between controller and target
// assumes both ends run from one system clock, with link quarters of at least five cycles
`timescale 1ns/100ps
module scp_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic hostSclOe,
  input wire logic devSdaO,
  input wire logic devSdaOe
);
  logic sclPrev_r;
  logic sdaPrev_r;
  logic busLive_r;
  logic firstByte_r;
  logic [3:0] riseCnt_r;
  logic [7:0] addrSh_r;
  logic startEv;
  logic stopEv;
  logic sclRise;
  logic ownAddr;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // line events; 7'h42 and 7'h44 are the map addresses the bench programs
  assign startEv = sclPrev_r && scl && sdaPrev_r && !sda;
  assign stopEv = sclPrev_r && scl && !sdaPrev_r && sda;
  assign sclRise = !sclPrev_r && scl;
  assign ownAddr = addrSh_r[7:2] == 6'h10 || addrSh_r[7:1] == 7'h42 || addrSh_r[7:1] == 7'h44;
  // delayed line levels
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= scl;
      sdaPrev_r <= sda;
    end
  end
  // frame open from start to stop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      busLive_r <= 1'b0;
    else if (startEv || stopEv)
      busLive_r <= startEv;
  end
  // rising link clocks since the last start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      riseCnt_r <= 4'h0;
    else if (startEv)
      riseCnt_r <= 4'h0;
    else if (sclRise && riseCnt_r != 4'hF)
      riseCnt_r <= riseCnt_r + 4'h1;
  end
  // first byte window, up to its ninth pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      firstByte_r <= 1'b0;
    else if (startEv || (sclRise && riseCnt_r == 4'h8))
      firstByte_r <= startEv;
  end
  // address byte as shifted on the wire
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      addrSh_r <= 8'h00;
    else if (sclRise && firstByte_r && riseCnt_r < 4'h8)
      addrSh_r <= {addrSh_r[6:0], sda};
  end
  a_ack_own_addr: assert property (sclRise && riseCnt_r == 4'h8 && firstByte_r && devSdaOe |-> ownAddr)
    else $error("address acknowledged that is not the target's");
  a_addr_no_drive: assert property (firstByte_r && scl && !sclRise && riseCnt_r <= 4'h8 |-> !devSdaOe)
    else $error("target drove data during the address byte");
  a_ack_held_high: assert property (sclRise && devSdaOe |=> devSdaOe [*8])
    else $error("target released data while clock high");
  a_dev_moves_low: assert property ($changed(devSdaOe) |-> !scl)
    else $error("target changed data while clock high");
  a_dev_open_drain: assert property (devSdaOe |-> devSdaO == 1'b0 && riseCnt_r >= 4'h8)
    else $error("target drove data high or before the eighth clock");
  a_idle_quiet: assert property (!busLive_r |-> !devSdaOe)
    else $error("target drives data outside a frame");
  a_scl_idle_high: assert property (!busLive_r |-> !hostSclOe && scl)
    else $error("link clock not released between frames");
  a_start_shape: assert property (startEv |-> scl [*4])
    else $error("clock fell too soon after start");
  a_stop_shape: assert property (stopEv |=> (scl && sda) [*4])
    else $error("lines not held high after stop");
endmodule : scp_monitor

// ==== serial_config_port_map_select_test.sv ====
// bench: apb-driven controller talks to the target across the shared link
// assumes scp_pkg, scp_if, scp_sync, scp_device, scp_host and scp_monitor compiled first
`timescale 1ns/100ps
module serial_config_port_map_select_test import scp_pkg::*; ();
  typedef struct packed {
    logic strap;
    logic [7:0] addr;
    logic [7:0] sub;
    logic [7:0] data;
    logic ack;
    logic rdOnly;
  } scp_row_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic addressSelectPin = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] subMapSelector;
  logic [7:0] postprocMapTargetAddress;
  logic [7:0] serialOutMapTargetAddress;
  logic busy;
  logic [8:0] wireBits = 9'h000;
  logic [7:0] q;
  logic [31:0] s;
  logic [31:0] r;
  logic e;
  int num_errors = 0;
  int checked = 0;
  // strap, address, subaddress, data, acknowledged, read-only check
  scp_row_t rows [13] = '{'{1'b0, 8'h40, 8'h10, 8'h5A, 1'b1, 1'b0}, '{1'b0, 8'h42, 8'h10, 8'h11, 1'b0, 1'b0},
    '{1'b1, 8'h42, 8'h11, 8'hA5, 1'b1, 1'b0}, '{1'b1, 8'h40, 8'h11, 8'h00, 1'b0, 1'b0},
    '{1'b0, 8'h40, 8'h0E, 8'h20, 1'b1, 1'b0}, '{1'b0, 8'h40, 8'h10, 8'hC3, 1'b1, 1'b0},
    '{1'b0, 8'h40, 8'h0E, 8'h40, 1'b1, 1'b0}, '{1'b0, 8'h40, 8'h10, 8'h77, 1'b1, 1'b0},
    '{1'b0, 8'h40, 8'h0E, 8'h00, 1'b1, 1'b0}, '{1'b0, 8'h40, 8'h10, 8'h5A, 1'b1, 1'b1},
    '{1'b0, 8'h84, 8'h10, 8'h00, 1'b0, 1'b0}, '{1'b0, 8'h40, 8'hFD, 8'h84, 1'b1, 1'b0},
    '{1'b0, 8'h84, 8'h10, 8'h3C, 1'b1, 1'b0}};
  scp_if i_scp_if();
  scp_host #(.QUARTER(8)) i_scp_host(.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(i_scp_if.host));
  scp_device i_scp_device(.clk(clk), .reset_n(reset_n), .link(i_scp_if.dev), .addressSelectPin(addressSelectPin),
    .subMapSelector(subMapSelector), .postprocMapTargetAddress(postprocMapTargetAddress),
    .serialOutMapTargetAddress(serialOutMapTargetAddress), .busy(busy));
  scp_monitor i_scp_monitor(.clk(clk), .reset_n(reset_n), .scl(i_scp_if.scl), .sda(i_scp_if.sda),
    .hostSclOe(i_scp_if.hostSclOe), .devSdaO(i_scp_if.devSdaO), .devSdaOe(i_scp_if.devSdaOe));
  // system clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  // data line as seen at each rising link clock
  always @(posedge i_scp_if.scl) begin
    wireBits <= {wireBits[7:0], i_scp_if.sda};
  end
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic wrap_up();
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // a wait ran out
  task automatic stall();
    num_errors++;
    $display("[ERR] %0t ns: wait ran out", $time);
    wrap_up();
  endtask : stall
  // one apb transfer, held until pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      stall();
  endtask : apb
  // poll status until the byte command is done
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(STAT_OFS, 1'b0, 32'h0000_0000);
      n++;
    end while (r[STAT_DONE_BIT] !== 1'b1 && n < 2000);
    s = r;
    if (n >= 2000)
      stall();
  endtask : wait_done
  // byte command; flags: 1 start, 2 stop, 4 read, 8 nack after read
  task automatic cmd(input logic [3:0] f, input logic [7:0] b);
    apb(CMD_OFS, 1'b1, {16'h0000, b, 4'h0, f});
    chk(e, 1'b0);
    wait_done();
    if (f[CMD_STOP_BIT] == 1'b0 && f[CMD_READ_BIT] == 1'b0)
      chk(wireBits, {b, !s[STAT_ACK_BIT]});
  endtask : cmd
  // single-register write; a refused address is closed by a dummy byte with stop
  task automatic wr(input logic [7:0] a, input logic [7:0] sb, input logic [7:0] d, input logic ak);
    cmd(4'h1, a);
    chk(s[STAT_ACK_BIT], ak);
    if (!ak) begin
      cmd(4'h2, 8'hFF);
    end else begin
      cmd(4'h0, sb);
      chk(s[STAT_ACK_BIT], 1'b1);
      cmd(4'h2, d);
      chk(s[STAT_ACK_BIT], 1'b1);
    end
  endtask : wr
  // single-register read through a repeated start
  task automatic rd(input logic [7:0] a, input logic [7:0] sb);
    cmd(4'h1, a & 8'hFE);
    cmd(4'h0, sb);
    cmd(4'h1, a | 8'h01);
    chk(s[STAT_ACK_BIT], 1'b1);
    cmd(4'hE, 8'h00);
    q = s[STAT_BYTE_LSB +: 8];
  endtask : rd
  // three-byte read from the main address
  task automatic rd3(input logic [7:0] sb, input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
    cmd(4'h1, 8'h40);
    cmd(4'h0, sb);
    cmd(4'h1, 8'h41);
    cmd(4'h4, 8'h00);
    chk(s[15:8], e0);
    cmd(4'h4, 8'h00);
    chk(s[15:8], e1);
    cmd(4'hE, 8'h00);
    chk(s[15:8], e2);
  endtask : rd3
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    foreach (rows[i]) begin
      addressSelectPin <= rows[i].strap;
      repeat (8) @(posedge clk);
      if (!rows[i].rdOnly)
        wr(rows[i].addr, rows[i].sub, rows[i].data, rows[i].ack);
      if (rows[i].ack) begin
        rd(rows[i].addr, rows[i].sub);
        chk(q, rows[i].data);
      end
      if (rows[i].ack && rows[i].sub == SUBMAP_SEL_OFS)
        chk(subMapSelector, rows[i].data);
    end
    chk(postprocMapTargetAddress, 8'h84);
    // burst write of three registers, read back as a burst
    cmd(4'h1, 8'h40);
    cmd(4'h0, 8'h20);
    cmd(4'h0, 8'hA1);
    cmd(4'h0, 8'hA2);
    cmd(4'h2, 8'hA3);
    rd3(8'h20, 8'hA1, 8'hA2, 8'hA3);
    // top register written, next byte refused and dropped
    cmd(4'h1, 8'h40);
    cmd(4'h0, 8'hFE);
    cmd(4'h0, 8'h88);
    chk(s[STAT_ACK_BIT], 1'b1);
    cmd(4'h2, 8'h11);
    chk(s[STAT_ACK_BIT], 1'b0);
    chk(serialOutMapTargetAddress, 8'h88);
    rd3(8'hFE, 8'h88, 8'h88, 8'h88);
    wr(8'h88, 8'h10, 8'h66, 1'b1);
    rd(8'h88, 8'h10);
    chk(q, 8'h66);
    // invalid subaddress refused, target idle at once
    cmd(4'h1, 8'h40);
    cmd(4'h0, 8'hFF);
    chk(s[STAT_ACK_BIT], 1'b0);
    chk(busy, 1'b0);
    cmd(4'h2, 8'h00);
    // stop straight after the subaddress ends the transfer
    cmd(4'h1, 8'h40);
    cmd(4'h2, 8'h10);
    chk(busy, 1'b0);
    rd(8'h40, 8'h10);
    chk(q, 8'h5A);
    // unmapped address and command while busy are refused
    apb(12'h008, 1'b1, 32'h0000_00FF);
    chk(e, 1'b1);
    apb(12'h008, 1'b0, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    apb(CMD_OFS, 1'b1, 32'h0000_4001);
    apb(CMD_OFS, 1'b1, 32'h0000_4001);
    chk(e, 1'b1);
    wait_done();
    // selector code 11 falls back to the user sub map
    cmd(4'h0, 8'h0E);
    cmd(4'h2, 8'h60);
    chk(subMapSelector, 8'h60);
    rd(8'h40, 8'h10);
    chk(q, 8'h5A);
    // reset in mid run clears the map controls
    reset_n <= 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk(subMapSelector, SEL_RESET);
    chk(postprocMapTargetAddress, PP_ADDR_RESET);
    chk(serialOutMapTargetAddress, SO_ADDR_RESET);
    wr(8'h84, 8'h10, 8'h00, 1'b0);
    wr(8'h88, 8'h10, 8'h00, 1'b0);
    wrap_up();
  end
endmodule : serial_config_port_map_select_test
